// ### hw/flash_host.sv
// Wishbone-controlled host that drives command sequences into a parallel NOR flash
// ==========================================
// Summary of operation
// - Autoselect only from read mode, never while another bank is busy.
// - Autoselect is two unlocks plus bank-addressed command; reads repeat freely.
// - Protection queries present bank and sector address.
// - Three-cycle entry selects secured region; four-cycle exit restores array.
// - Program is two unlocks, set-up, then address with data.
// - Bypass entry is two unlocks plus 20h; program is A0h, address/data.
// - Bypass accepts only program and exit; exit is 90h then 00h.
// - Wrong or out-of-order writes need a reset to recover.
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_regs.svh"

module flash_host #(
  parameter logic [flash_host_pkg::AW-1:0] UNLOCK1_ADDR = 22'h00_0555,
  parameter logic [flash_host_pkg::AW-1:0] UNLOCK2_ADDR = 22'h00_02AA,
  parameter logic [7:0] UNLOCK1_DATA = 8'hAA,
  parameter logic [7:0] UNLOCK2_DATA = 8'h55,
  parameter logic [7:0] CMD_RESET = 8'hF0,
  parameter logic [7:0] CMD_AUTOSEL = 8'h90,
  parameter logic [7:0] CMD_SEC_ENTER = 8'h88,
  parameter logic [7:0] CMD_SEC_EXIT = 8'h90,
  parameter logic [7:0] CMD_PROGRAM = 8'hA0,
  parameter logic [7:0] CMD_BYP_ENTER = 8'h20,
  parameter logic [7:0] CMD_BYP_PROG = 8'hA0,
  parameter logic [7:0] CMD_BYP_EXIT1 = 8'h90,
  parameter logic [7:0] CMD_BYP_EXIT2 = 8'h00
) (
  input wire logic CLOCK_I, // 50 MHz clock
  input wire logic RESET_I, // Synchronous reset, high
  input wire logic CLK_EN_I, // Freezes all state when low
  input wire logic [7:0] ADR_I, // Wishbone address
  input wire logic [31:0] DAT_I, // Wishbone write data
  input wire logic [3:0] SEL_I, // Wishbone byte selects
  input wire logic WE_I, // Wishbone write
  input wire logic CYC_I, // Wishbone cycle
  input wire logic STB_I, // Wishbone strobe
  output logic [31:0] DAT_O, // Wishbone read data
  output logic ACK_O, // Wishbone acknowledge
  output logic FL_CE_N_O, // Flash chip enable, low
  output logic FL_OE_N_O, // Flash output enable, low
  output logic FL_WE_N_O, // Flash write enable, low
  output logic [flash_host_pkg::AW-1:0] FL_ADDR_O, // Flash address
  output logic [flash_host_pkg::DW-1:0] FL_DQ_O, // Flash data out
  output logic FL_DQ_OE_N_O, // Low while host drives data
  input wire logic [flash_host_pkg::DW-1:0] FL_DQ_I, // Flash data in
  input wire logic FL_READY_BUSY_N_I, // ready_busy_n from flash
  output logic FL_BYTE_WORD_O, // byte_word_select, high for word
  output logic FL_ACCEL_O, // Requests high voltage on protect_accel_pin
  output logic FL_RESET_N_O // Flash hardware reset, low
);
  localparam int AW = flash_host_pkg::AW;
  localparam int DW = flash_host_pkg::DW;

  // ==========================================
  // Software-facing registers
  flash_host_pkg::op_e op_req_ff;
  logic [AW-1:0] addr_ff;
  logic [DW-1:0] wdata_ff;
  logic byte_ff;
  logic accel_ff;
  logic hwrst_ff;
  logic go_ff;
  logic clr_ff;
  logic [DW-1:0] rdata_ff;
  logic fail_ff;
  logic refused_ff;
  logic wb_hit;
  logic [31:0] nxt_dat;

  // ==========================================
  // Sequencer state
  flash_host_pkg::state_e state_ff;
  flash_host_pkg::mode_e mode_ff;
  flash_host_pkg::op_e op_ff;
  logic [2:0] step_ff;
  logic [3:0] cnt_ff;
  logic poll_ff;
  logic exceeded_ff;
  flash_host_pkg::pins_s pins_ff;
  flash_host_pkg::pins_s nxt_step;
  logic [2:0] nsteps;
  logic allowed;
  logic last_step;

  assign wb_hit = CYC_I & STB_I & ~ACK_O;

  // Read mux; unmapped offsets read zero
  always_comb begin
    nxt_dat = 32'h0000_0000;
    case (ADR_I)
      `REG_CTRL: begin
        nxt_dat[`CTRL_OP_MSB:`CTRL_OP_LSB] = op_req_ff;
        nxt_dat[`CTRL_BYTE] = byte_ff;
        nxt_dat[`CTRL_ACCEL] = accel_ff;
        nxt_dat[`CTRL_HWRST] = hwrst_ff;
      end
      `REG_ADDR: nxt_dat[AW-1:0] = addr_ff;
      `REG_WDATA: nxt_dat[DW-1:0] = wdata_ff;
      `REG_STATUS: begin
        nxt_dat[`STAT_BUSY] = (state_ff != flash_host_pkg::S_IDLE);
        nxt_dat[`STAT_FAIL] = fail_ff;
        nxt_dat[`STAT_REFUSED] = refused_ff;
        nxt_dat[`STAT_READY] = FL_READY_BUSY_N_I;
        nxt_dat[`STAT_MODE_MSB:`STAT_MODE_LSB] = mode_ff;
      end
      `REG_RDATA: nxt_dat[DW-1:0] = rdata_ff;
      default: nxt_dat = 32'h0000_0000;
    endcase
  end

  // Wishbone slave: one wait state, ack always one cycle
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
      op_req_ff <= flash_host_pkg::OP_READ;
      addr_ff <= '0;
      wdata_ff <= '0;
      byte_ff <= 1'b1;
      accel_ff <= 1'b0;
      hwrst_ff <= 1'b0;
      go_ff <= 1'b0;
      clr_ff <= 1'b0;
    end else if (CLK_EN_I) begin
      ACK_O <= wb_hit;
      DAT_O <= nxt_dat;
      go_ff <= 1'b0;
      clr_ff <= 1'b0;
      if (wb_hit & WE_I) begin
        case (ADR_I)
          `REG_CTRL: begin
            if (SEL_I[0]) begin
              op_req_ff <= flash_host_pkg::op_e'(DAT_I[`CTRL_OP_MSB:`CTRL_OP_LSB]);
              go_ff <= DAT_I[`CTRL_START];
            end
            if (SEL_I[1]) begin
              byte_ff <= DAT_I[`CTRL_BYTE];
              accel_ff <= DAT_I[`CTRL_ACCEL];
              hwrst_ff <= DAT_I[`CTRL_HWRST];
            end
          end
          `REG_ADDR: begin
            if (SEL_I[0]) addr_ff[7:0] <= DAT_I[7:0];
            if (SEL_I[1]) addr_ff[15:8] <= DAT_I[15:8];
            if (SEL_I[2]) addr_ff[AW-1:16] <= DAT_I[AW-1:16];
          end
          `REG_WDATA: begin
            if (SEL_I[0]) wdata_ff[7:0] <= DAT_I[7:0];
            if (SEL_I[1]) wdata_ff[15:8] <= DAT_I[15:8];
          end
          `REG_STATUS: clr_ff <= 1'b1;
          default: clr_ff <= 1'b0;
        endcase
      end
    end
  end

  // Number of write cycles per operation
  always_comb begin
    case (op_ff)
      flash_host_pkg::OP_RESET: nsteps = 3'd1;
      flash_host_pkg::OP_SEC_EXIT: nsteps = 3'd4;
      flash_host_pkg::OP_PROGRAM: nsteps = 3'd4;
      flash_host_pkg::OP_BYP_PROG: nsteps = 3'd2;
      flash_host_pkg::OP_BYP_EXIT: nsteps = 3'd2;
      flash_host_pkg::OP_READ: nsteps = 3'd0;
      default: nsteps = 3'd3;
    endcase
  end
  assign last_step = (step_ff == nsteps - 3'd1);

  // Address and data of the current command cycle
  always_comb begin
    nxt_step = pins_ff;
    nxt_step.addr = UNLOCK1_ADDR;
    nxt_step.dq = {8'h00, UNLOCK1_DATA};
    if (op_ff == flash_host_pkg::OP_RESET) begin
      nxt_step.addr = addr_ff;
      nxt_step.dq = {8'h00, CMD_RESET};
    end else if (op_ff == flash_host_pkg::OP_BYP_PROG) begin
      nxt_step.addr = (step_ff == 3'd0) ? UNLOCK1_ADDR : addr_ff;
      nxt_step.dq = (step_ff == 3'd0) ? {8'h00, CMD_BYP_PROG} : wdata_ff;
    end else if (op_ff == flash_host_pkg::OP_BYP_EXIT) begin
      // 90h with bank address, then 00h
      nxt_step.addr = addr_ff;
      nxt_step.dq = {8'h00, (step_ff == 3'd0) ? CMD_BYP_EXIT1 : CMD_BYP_EXIT2};
    end else if (step_ff == 3'd1) begin
      nxt_step.addr = UNLOCK2_ADDR;
      nxt_step.dq = {8'h00, UNLOCK2_DATA};
    end else if (step_ff == 3'd2) begin
      case (op_ff)
        flash_host_pkg::OP_AUTOSEL: begin
          nxt_step.addr = addr_ff;
          nxt_step.dq = {8'h00, CMD_AUTOSEL};
        end
        flash_host_pkg::OP_SEC_ENTER: nxt_step.dq = {8'h00, CMD_SEC_ENTER};
        flash_host_pkg::OP_SEC_EXIT: nxt_step.dq = {8'h00, CMD_SEC_EXIT};
        flash_host_pkg::OP_BYP_ENTER: nxt_step.dq = {8'h00, CMD_BYP_ENTER};
        default: nxt_step.dq = {8'h00, CMD_PROGRAM};
      endcase
    end else if (step_ff == 3'd3) begin
      // fourth cycle carries target address and data for program, 00h for secured exit
      nxt_step.addr = (op_ff == flash_host_pkg::OP_PROGRAM) ? addr_ff : UNLOCK1_ADDR;
      nxt_step.dq = (op_ff == flash_host_pkg::OP_PROGRAM) ? wdata_ff : 16'h0000;
    end
  end

  // Mode checks before a request is taken
  always_comb begin
    allowed = 1'b1;
    case (op_req_ff)
      flash_host_pkg::OP_AUTOSEL: allowed = (mode_ff == flash_host_pkg::MODE_READ) & FL_READY_BUSY_N_I;
      // no bypass while secured region is on
      flash_host_pkg::OP_BYP_ENTER: allowed = (mode_ff == flash_host_pkg::MODE_READ);
      flash_host_pkg::OP_BYP_PROG: allowed = (mode_ff == flash_host_pkg::MODE_BYP);
      flash_host_pkg::OP_BYP_EXIT: allowed = (mode_ff == flash_host_pkg::MODE_BYP) & ~accel_ff;
      // reset recovers stray sequences, except in bypass
      flash_host_pkg::OP_RESET: allowed = (mode_ff != flash_host_pkg::MODE_BYP);
      flash_host_pkg::OP_READ: allowed = 1'b1;
      flash_host_pkg::OP_SEC_EXIT: allowed = (mode_ff == flash_host_pkg::MODE_SEC);
      // bypass accepts only its own program and exit
      default: allowed = (mode_ff == flash_host_pkg::MODE_READ) | (mode_ff == flash_host_pkg::MODE_SEC);
    endcase
  end

  // Bus sequencer; strobes never overlap so address and data edges are unambiguous
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      state_ff <= flash_host_pkg::S_IDLE;
      op_ff <= flash_host_pkg::OP_READ;
      step_ff <= 3'd0;
      cnt_ff <= 4'd0;
      poll_ff <= 1'b0;
      exceeded_ff <= 1'b0;
      pins_ff <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq: '0, dq_oe_n: 1'b1};
    end else if (CLK_EN_I) begin
      cnt_ff <= cnt_ff + 4'd1;
      case (state_ff)
        flash_host_pkg::S_IDLE: begin
          pins_ff.ce_n <= 1'b1;
          pins_ff.oe_n <= 1'b1;
          pins_ff.we_n <= 1'b1;
          pins_ff.dq_oe_n <= 1'b1;
          exceeded_ff <= 1'b0;
          poll_ff <= 1'b0;
          step_ff <= 3'd0;
          cnt_ff <= 4'd0;
          if (go_ff & allowed & ~hwrst_ff) begin
            op_ff <= op_req_ff;
            state_ff <= (op_req_ff == flash_host_pkg::OP_READ) ? flash_host_pkg::S_READ
                                                               : flash_host_pkg::S_SETUP;
          end
        end
        // address settles with chip enable, write enable falls later
        flash_host_pkg::S_SETUP: begin
          pins_ff.ce_n <= 1'b0;
          pins_ff.addr <= nxt_step.addr;
          pins_ff.dq <= nxt_step.dq;
          pins_ff.dq_oe_n <= 1'b0;
          if (cnt_ff >= 4'(`SETUP_CYC - 1)) begin
            cnt_ff <= 4'd0;
            state_ff <= flash_host_pkg::S_STROBE;
          end
        end
        flash_host_pkg::S_STROBE: begin
          pins_ff.we_n <= 1'b0;
          if (cnt_ff >= 4'(`WP_CYC - 1)) begin
            cnt_ff <= 4'd0;
            state_ff <= flash_host_pkg::S_HOLD;
          end
        end
        // Data latched on write enable rising before chip enable releases
        flash_host_pkg::S_HOLD: begin
          pins_ff.we_n <= 1'b1;
          if (cnt_ff == 4'd0) begin
            pins_ff.ce_n <= 1'b0;
          end else begin
            pins_ff.ce_n <= 1'b1;
            pins_ff.dq_oe_n <= 1'b1;
          end
          if (cnt_ff >= 4'(`WPH_CYC)) begin
            cnt_ff <= 4'd0;
            step_ff <= step_ff + 3'd1;
            if (!last_step) begin
              state_ff <= flash_host_pkg::S_SETUP;
            // watch progress after the program cycle
            end else if (op_ff == flash_host_pkg::OP_PROGRAM || op_ff == flash_host_pkg::OP_BYP_PROG) begin
              poll_ff <= 1'b1;
              state_ff <= flash_host_pkg::S_GAP;
            end else begin
              state_ff <= flash_host_pkg::S_IDLE;
            end
          end
        end
        // reads present the caller's full bank and sector address
        flash_host_pkg::S_READ: begin
          pins_ff.ce_n <= 1'b0;
          pins_ff.oe_n <= 1'b0;
          pins_ff.dq_oe_n <= 1'b1;
          pins_ff.addr <= addr_ff;
          if (cnt_ff >= 4'(`ACC_CYC)) begin
            cnt_ff <= 4'd0;
            pins_ff.oe_n <= 1'b1;
            pins_ff.ce_n <= 1'b1;
            if (!poll_ff) begin
              state_ff <= flash_host_pkg::S_IDLE;
            // no commands while busy, keep polling
            end else if (!FL_READY_BUSY_N_I) begin
              // timing flag marks a failed program
              if (FL_DQ_I[`DQ_EXCEEDED]) exceeded_ff <= 1'b1;
              state_ff <= flash_host_pkg::S_GAP;
            // recover with a reset after a timing failure
            end else if (exceeded_ff) begin
              op_ff <= flash_host_pkg::OP_RESET;
              poll_ff <= 1'b0;
              step_ff <= 3'd0;
              state_ff <= flash_host_pkg::S_SETUP;
            end else begin
              state_ff <= flash_host_pkg::S_IDLE;
            end
          end
        end
        flash_host_pkg::S_GAP: begin
          cnt_ff <= 4'd0;
          state_ff <= flash_host_pkg::S_READ;
        end
        default: state_ff <= flash_host_pkg::S_IDLE;
      endcase
      if (hwrst_ff) begin
        // hardware reset aborts everything at once
        state_ff <= flash_host_pkg::S_IDLE;
      end
    end
  end

  // Read data capture and sticky flags; a new event beats a clear
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      rdata_ff <= '0;
      fail_ff <= 1'b0;
      refused_ff <= 1'b0;
    end else if (CLK_EN_I) begin
      if (state_ff == flash_host_pkg::S_READ && cnt_ff >= 4'(`ACC_CYC)) begin
        rdata_ff <= FL_DQ_I;
      end
      if (state_ff == flash_host_pkg::S_READ && cnt_ff >= 4'(`ACC_CYC) && poll_ff
          && FL_READY_BUSY_N_I && exceeded_ff) begin
        fail_ff <= 1'b1;
      end else if (clr_ff) begin
        fail_ff <= 1'b0;
      end
      if (go_ff && (state_ff != flash_host_pkg::S_IDLE || !allowed || hwrst_ff)) begin
        refused_ff <= 1'b1;
      end else if (clr_ff) begin
        refused_ff <= 1'b0;
      end
    end
  end

  // Host view of the bank mode
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      mode_ff <= flash_host_pkg::MODE_READ;
    end else if (CLK_EN_I) begin
      if (hwrst_ff) begin
        mode_ff <= flash_host_pkg::MODE_READ;
      // high voltage puts the bank in bypass on its own
      end else if (FL_ACCEL_O) begin
        mode_ff <= flash_host_pkg::MODE_BYP;
      end else if (state_ff == flash_host_pkg::S_HOLD && cnt_ff >= 4'(`WPH_CYC) && last_step) begin
        case (op_ff)
          flash_host_pkg::OP_RESET: mode_ff <= (mode_ff == flash_host_pkg::MODE_SEC) ? mode_ff
                                                                                    : flash_host_pkg::MODE_READ;
          flash_host_pkg::OP_AUTOSEL: mode_ff <= flash_host_pkg::MODE_AUTO;
          flash_host_pkg::OP_SEC_ENTER: mode_ff <= flash_host_pkg::MODE_SEC;
          flash_host_pkg::OP_SEC_EXIT: mode_ff <= flash_host_pkg::MODE_READ;
          flash_host_pkg::OP_BYP_ENTER: mode_ff <= flash_host_pkg::MODE_BYP;
          flash_host_pkg::OP_BYP_EXIT: mode_ff <= flash_host_pkg::MODE_READ;
          default: mode_ff <= mode_ff;
        endcase
      end
    end
  end

  // Pin outputs, all from flip-flops
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      FL_CE_N_O <= 1'b1;
      FL_OE_N_O <= 1'b1;
      FL_WE_N_O <= 1'b1;
      FL_ADDR_O <= '0;
      FL_DQ_O <= '0;
      FL_DQ_OE_N_O <= 1'b1;
      FL_BYTE_WORD_O <= 1'b1;
      FL_ACCEL_O <= 1'b0;
      FL_RESET_N_O <= 1'b1;
    end else if (CLK_EN_I) begin
      FL_CE_N_O <= pins_ff.ce_n;
      FL_OE_N_O <= pins_ff.oe_n;
      FL_WE_N_O <= pins_ff.we_n;
      FL_ADDR_O <= pins_ff.addr;
      FL_DQ_O <= pins_ff.dq;
      FL_DQ_OE_N_O <= pins_ff.dq_oe_n;
      FL_BYTE_WORD_O <= byte_ff;
      FL_ACCEL_O <= accel_ff & (mode_ff != flash_host_pkg::MODE_SEC);
      FL_RESET_N_O <= ~hwrst_ff;
    end
  end
endmodule : flash_host
`default_nettype wire

// ### include/flash_host_pkg.sv
// Types shared by the flash command host
package flash_host_pkg;
  localparam int AW = 22;
  localparam int DW = 16;

  // ==========================================
  // Operations that software may start
  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_RESET = 4'h1,
    OP_AUTOSEL = 4'h2,
    OP_SEC_ENTER = 4'h3,
    OP_SEC_EXIT = 4'h4,
    OP_PROGRAM = 4'h5,
    OP_BYP_ENTER = 4'h6,
    OP_BYP_PROG = 4'h7,
    OP_BYP_EXIT = 4'h8
  } op_e;

  // Bank mode as seen from the host
  typedef enum logic [3:0] {
    MODE_READ = 4'b0001,
    MODE_AUTO = 4'b0010,
    MODE_SEC = 4'b0100,
    MODE_BYP = 4'b1000
  } mode_e;

  // Bus sequencer states
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_SETUP = 6'b000010,
    S_STROBE = 6'b000100,
    S_HOLD = 6'b001000,
    S_READ = 6'b010000,
    S_GAP = 6'b100000
  } state_e;

  // Flash pin bundle driven by the host
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [AW-1:0] addr;
    logic [DW-1:0] dq;
    logic dq_oe_n;
  } pins_s;
endpackage : flash_host_pkg

// ### include/flash_host_regs.svh
// Register offsets, field positions and timing counts of the flash command host
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH
// ==========================================
// Register offsets (byte addresses)
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_STATUS 8'h0C
`define REG_RDATA 8'h10
// ==========================================
// Control fields
`define CTRL_OP_LSB 0
`define CTRL_OP_MSB 3
`define CTRL_START 4
`define CTRL_BYTE 8
`define CTRL_ACCEL 9
`define CTRL_HWRST 10
// ==========================================
// Status fields
`define STAT_BUSY 0
`define STAT_FAIL 1
`define STAT_REFUSED 2
`define STAT_READY 3
`define STAT_MODE_LSB 4
`define STAT_MODE_MSB 7
// ==========================================
// Device status bit positions on the data lines
`define DQ_EXCEEDED 5
`define DQ_TOGGLE 6
`define DQ_POLLING 7
// ==========================================
// Timing in ns and derived cycle counts at the clock rate
`define CLK_MHZ 50
`define T_SETUP_NS 20
`define T_WP_NS 35
`define T_WPH_NS 30
`define T_ACC_NS 70
`define CYC(ns) ((((ns) * `CLK_MHZ + 999) / 1000) < 1 ? 1 : (((ns) * `CLK_MHZ + 999) / 1000))
`define SETUP_CYC `CYC(`T_SETUP_NS)
`define WP_CYC `CYC(`T_WP_NS)
`define WPH_CYC `CYC(`T_WPH_NS)
`define ACC_CYC `CYC(`T_ACC_NS)
`endif

// ### testbench/flash_dev_model.sv
// Behavioural flash bank answering the host
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
  parameter logic [15:0] ID_CODE = 16'h005A, // Arbitrary identification value
  parameter logic [15:0] SERIAL = 16'h0C3E, // Arbitrary serial word
  parameter int PROG_CYC = 12 // Program time in cycles
) (
  input wire logic clk_i, // Clock
  input wire logic ce_n_i, // Chip enable
  input wire logic oe_n_i, // Output enable
  input wire logic we_n_i, // Write enable
  input wire logic rst_n_i, // Hardware reset
  input wire logic accel_i, // High voltage present
  input wire logic bw_i, // byte_word_select
  input wire logic [21:0] addr_i, // Address
  input wire logic [15:0] dq_i, // Data wire
  output logic [15:0] dq_o, // Read data
  output logic ready_busy_n_o // ready_busy_n
);
  // ==========================================
  // Array and command state
  logic [15:0] mem [16], pd_ff, rv;
  logic [21:0] la_ff;
  logic [2:0] step_ff;
  logic [1:0] mode_ff; // 0 read, 1 autoselect, 2 secured, 3 bypass
  logic wq_ff, flag_ff, tog_ff;
  int busy_ff;
  initial begin
    foreach (mem[k]) mem[k] = 16'hFFFF;
    {step_ff, mode_ff, flag_ff, tog_ff, busy_ff, dq_o} = '0;
    wq_ff = 1'b1;
  end
  assign ready_busy_n_o = (busy_ff == 0);
  assign rv = (busy_ff != 0) ? {8'h00, ~pd_ff[7], tog_ff, flag_ff, 5'h00} :
    (mode_ff == 1) ? ID_CODE : (mode_ff == 2) ? SERIAL : mem[addr_i[3:0]];
  // Inverts when idle so stale data never passes
  always @(posedge clk_i) dq_o <= (ce_n_i || oe_n_i) ? ~dq_o : rv;
  always @(posedge clk_i) begin
    wq_ff <= we_n_i;
    tog_ff <= tog_ff ^ (busy_ff != 0);
    if (busy_ff != 0) busy_ff <= busy_ff - 1;
    if (!ce_n_i && !we_n_i && wq_ff) la_ff <= addr_i;
    if (accel_i && mode_ff != 2) mode_ff <= 2'd3;
    if (!rst_n_i) begin
      {busy_ff, step_ff, mode_ff, flag_ff} <= '0;
    end else if (!ce_n_i && we_n_i && !wq_ff && busy_ff == 0) begin
      step_ff <= 3'd0;
      if (step_ff == 4) begin
        mem[la_ff[3:0]] <= mem[la_ff[3:0]] & (dq_i | (bw_i ? 16'h0000 : 16'hFF00));
        flag_ff <= |(dq_i & ~mem[la_ff[3:0]] & (bw_i ? 16'hFFFF : 16'h00FF));
        pd_ff <= dq_i;
        busy_ff <= PROG_CYC;
      end else if (step_ff == 5) begin
        if (dq_i[7:0] == 8'h00) mode_ff <= 2'd0;
      end else if (dq_i[7:0] == 8'hF0) begin
        flag_ff <= 1'b0;
        if (mode_ff == 1) mode_ff <= 2'd0;
      end else if (mode_ff == 3 && step_ff == 0) begin
        step_ff <= (dq_i[7:0] == 8'hA0) ? 3'd4 : (dq_i[7:0] == 8'h90) ? 3'd5 : 3'd0;
      end else if (step_ff == 0 && dq_i[7:0] == 8'hAA && la_ff == 22'h555) step_ff <= 3'd1;
      else if (step_ff == 1 && dq_i[7:0] == 8'h55 && la_ff == 22'h2AA) step_ff <= 3'd2;
      else if (step_ff == 2) begin
        case (dq_i[7:0])
          8'hA0: step_ff <= 3'd4;
          8'h90: if (mode_ff == 2) step_ff <= 3'd5; else mode_ff <= 2'd1;
          8'h88: mode_ff <= 2'd2;
          8'h20: if (mode_ff != 2) mode_ff <= 2'd3;
          default: ;
        endcase
      end
    end
  end
endmodule : flash_dev_model
`default_nettype wire

// ### testbench/flash_host_assertions.sv
// Port checks on the flash command host
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_regs.svh"
module flash_host_assertions (
  input wire logic CLOCK_I, // Clock
  input wire logic RESET_I, // Reset
  input wire logic CLK_EN_I, // Clock enable
  input wire logic CYC_I, // Cycle
  input wire logic STB_I, // Strobe
  input wire logic WE_I, // Write
  input wire logic [7:0] ADR_I, // Address
  input wire logic [31:0] DAT_I, // Write data
  input wire logic ACK_O, // Ack
  input wire logic FL_CE_N_O, // Chip enable
  input wire logic FL_WE_N_O, // Write enable
  input wire logic FL_DQ_OE_N_O, // Data drive
  input wire logic FL_BYTE_WORD_O, // Byte or word
  input wire logic FL_RESET_N_O // Hardware reset
);
  // ==========================================
  // Strobe shape sequences
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);
  logic ctl_wr;
  assign ctl_wr = CYC_I && STB_I && WE_I && !ACK_O && ADR_I == `REG_CTRL;
  sequence we_pulse; !FL_WE_N_O [*2] ##1 FL_WE_N_O; endsequence
  sequence ce_release; !FL_CE_N_O ##1 FL_CE_N_O; endsequence
  a_ack_once: assert property (ACK_O |=> !ACK_O) else $error("ack held");
  a_ack_reply: assert property (CLK_EN_I && CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("no ack");
  a_we_in_ce: assert property (!FL_WE_N_O |-> !FL_CE_N_O) else $error("we outside ce");
  a_we_drives: assert property (!FL_WE_N_O |-> !FL_DQ_OE_N_O) else $error("data not driven");
  a_we_width: assert property ($fell(FL_WE_N_O) |-> we_pulse) else $error("we width");
  a_ce_after_we: assert property ($rose(FL_WE_N_O) |-> ce_release) else $error("ce rise");
  a_hw_reset: assert property (ctl_wr && DAT_I[10] |-> ##[1:4] !FL_RESET_N_O) else $error("hw reset");
  a_byte_sel: assert property (ctl_wr && !DAT_I[8] |-> ##[1:4] !FL_BYTE_WORD_O) else $error("byte");
endmodule : flash_host_assertions
bind flash_host flash_host_assertions u_flash_host_assertions (.CLOCK_I, .RESET_I, .CLK_EN_I, .CYC_I, .STB_I, .WE_I,
  .ADR_I, .DAT_I, .ACK_O, .FL_CE_N_O, .FL_WE_N_O, .FL_DQ_OE_N_O, .FL_BYTE_WORD_O, .FL_RESET_N_O);
`default_nettype wire

// ### testbench/tb_flash_host.sv
// Self-checking bench for the flash command host
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_regs.svh"
module tb_flash_host;
  // ==========================================
  // Wiring and table
  localparam logic [15:0] ID_CODE = 16'h005A; // Arbitrary identification value
  localparam logic [15:0] SERIAL = 16'h0C3E; // Arbitrary serial word
  typedef struct packed {logic [3:0] op; logic [2:0] ctl; logic [21:0] a; logic [15:0] d; logic [7:0] st;
    logic [15:0] rd;} row_s;
  logic clk = 0, rst = 1, we = 0, cyc = 0, stb = 0, en = 1, ack, ce_n, oe_n, wen, dq_oe_n, rb_n, bw, acc, hrst_n;
  logic [7:0] adr = 0;
  logic [31:0] dw = 0, dr, q;
  logic [3:0] sel = 0;
  logic [21:0] fa;
  logic [15:0] fq, mq, bus;
  int fails = 0, n_tests = 0;
  row_s rows [15] = '{
    '{4'h5, 3'h1, 22'h3, 16'h1234, 8'h18, 16'h1234},
    '{4'h2, 3'h1, 22'h0, 16'h0, 8'h28, ID_CODE},
    '{4'h5, 3'h1, 22'h3, 16'h0, 8'h2C, ID_CODE},
    '{4'h1, 3'h1, 22'h3, 16'h0, 8'h18, 16'h1234},
    '{4'h6, 3'h1, 22'h3, 16'h0, 8'h88, 16'h1234},
    '{4'h7, 3'h1, 22'h3, 16'h1200, 8'h88, 16'h1200},
    '{4'h1, 3'h1, 22'h3, 16'h0, 8'h8C, 16'h1200},
    '{4'h8, 3'h1, 22'h3, 16'h0, 8'h18, 16'h1200},
    '{4'h5, 3'h0, 22'h5, 16'hAB00, 8'h18, 16'hFF00},
    '{4'h5, 3'h1, 22'h3, 16'hFFFF, 8'h1A, 16'h1200},
    '{4'h3, 3'h1, 22'h3, 16'h0, 8'h48, SERIAL},
    '{4'h6, 3'h1, 22'h3, 16'h0, 8'h4C, SERIAL},
    '{4'h4, 3'h1, 22'h3, 16'h0, 8'h18, 16'h1200},
    '{4'h7, 3'h3, 22'h7, 16'h00FF, 8'h88, 16'h00FF},
    '{4'h8, 3'h1, 22'h7, 16'h0, 8'h18, 16'h00FF}};
  // Shared data wire, host drives while its enable is low
  assign bus = dq_oe_n ? mq : fq;
  flash_host u_flash_host (.CLOCK_I(clk), .RESET_I(rst), .CLK_EN_I(en), .ADR_I(adr), .DAT_I(dw), .SEL_I(sel),
    .WE_I(we), .CYC_I(cyc), .STB_I(stb), .DAT_O(dr), .ACK_O(ack), .FL_CE_N_O(ce_n), .FL_OE_N_O(oe_n),
    .FL_WE_N_O(wen), .FL_ADDR_O(fa), .FL_DQ_O(fq), .FL_DQ_OE_N_O(dq_oe_n), .FL_DQ_I(bus),
    .FL_READY_BUSY_N_I(rb_n), .FL_BYTE_WORD_O(bw), .FL_ACCEL_O(acc), .FL_RESET_N_O(hrst_n));
  flash_dev_model #(.ID_CODE(ID_CODE), .SERIAL(SERIAL)) u_flash_dev_model (.clk_i(clk), .ce_n_i(ce_n),
    .oe_n_i(oe_n), .we_n_i(wen), .rst_n_i(hrst_n), .accel_i(acc), .bw_i(bw), .addr_i(fa), .dq_i(bus),
    .dq_o(mq), .ready_busy_n_o(rb_n));
  initial forever #10 clk = ~clk;
  // ==========================================
  // Bus cycle, operation and compare tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    {cyc, stb, we, adr, dw, sel} <= {2'b11, w, a, d, 4'hF};
    // No limit here: only the watchdog may end a wait for the answer
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = dr;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic run_op(input logic [3:0] op, input logic [2:0] ctl, input logic [21:0] a, input logic [15:0] d);
    int i;
    wb(`REG_STATUS, 1'b1, 32'h0, q);
    wb(`REG_ADDR, 1'b1, 32'(a), q);
    wb(`REG_WDATA, 1'b1, 32'(d), q);
    // Levels first, so accel mode is in place when start is judged
    wb(`REG_CTRL, 1'b1, {21'h0, ctl, 4'h0, op}, q);
    wb(`REG_CTRL, 1'b1, {21'h0, ctl, 3'h0, 1'b1, op}, q);
    repeat (3) @(posedge clk);
    i = 0;
    do begin
      wb(`REG_STATUS, 1'b0, 32'h0, q);
      i++;
    end while (q[`STAT_BUSY] !== 1'b0 && i < 400);
    chk("idle", 32'h0, 32'(q[`STAT_BUSY]));
  endtask : run_op
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  // Watchdog, far beyond the expected run of some 20 us
  initial begin
    #1_000_000;
    fails++;
    test_done();
  end
  // ==========================================
  // Table loop, then reset and hardware reset
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[k]) begin
      run_op(rows[k].op, rows[k].ctl, rows[k].a, rows[k].d);
      chk("status", 32'(rows[k].st), 32'(q[7:0]));
      run_op(4'h0, rows[k].ctl | 3'h1, rows[k].a, 16'h0);
      wb(`REG_RDATA, 1'b0, 32'h0, q);
      chk("rdata", 32'(rows[k].rd), 32'(q[15:0]));
      $display("row %0d done", k);
    end
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("idle pins", 32'h5, {29'h0, ce_n, ack, hrst_n});
    @(posedge clk) rst <= 1'b0;
    wb(`REG_STATUS, 1'b0, 32'h0, q);
    chk("reset mode", 32'h18, 32'(q[7:0]));
    wb(8'h40, 1'b0, 32'h0, q);
    chk("unmapped", 32'h0, q);
    $display("reset test done");
    // A low clock enable must freeze the bus answer
    @(posedge clk);
    {en, cyc, stb, we, adr} <= {4'b0110, `REG_STATUS};
    repeat (2) @(posedge clk);
    chk("frozen ack", 32'h0, {31'h0, ack});
    {en, cyc, stb} <= 3'b100;
    $display("clock enable test done");
    wb(`REG_CTRL, 1'b1, 32'h0000_0500, q);
    repeat (4) @(posedge clk);
    chk("hw reset", 32'h0, {31'h0, hrst_n});
    $display("hardware reset test done");
    test_done();
  end
endmodule : tb_flash_host
`default_nettype wire
